// file: src/fwe_top.sv
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fwe_params.svh"

// Functional notes
// - flags of two devices may differ one cycle
// - chained depth equals sum of depths
// - first word ripples down without reads
// - output ready low when word present
// - ripple delay (N-1)*4 plus 3 cycles
// - only the first word sees ripple delay
// - freed location lowers input ready upstream
module fwe_top (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output      logic [31:0]         avs_readdata,
  output      logic                avs_waitrequest,
  input  wire logic                wr_en_n,
  input  wire fwe_pkg::fwe_data_t  wr_data,
  output      logic                input_ready_n,
  input  wire logic                rd_en_n,
  output      fwe_pkg::fwe_data_t  rd_data,
  output      logic                output_ready_n
);

  fwe_pkg::fwe_data_t        q     [0:`FWE_STAGES-1];
  fwe_pkg::fwe_flags_t       flg   [0:`FWE_STAGES-1];
  logic [`FWE_CNT_W-1:0]     lvl   [0:`FWE_STAGES-1];
  logic [`FWE_TOT_W-1:0]     lvl_total;
  logic                      wait_ff;
  logic                      clr_ff;
  logic [31:0]               rdata_ff;
  logic [1:0]                reg_idx;
  logic                      first_take;
  logic [3:0]                ripple_cnt_ff;
  logic                      ripple_run_ff;

  // ========================================================================
  // Chain of stages, each handing words on its own ready flags
  genvar k;
  generate
    for (k = 0; k < `FWE_STAGES; k++)
    begin : g_stage
      logic               st_wr;
      logic               st_rd;
      fwe_pkg::fwe_data_t st_din;
      if (k == 0)
      begin : g_head
        assign st_wr  = !wr_en_n;
        assign st_din = wr_data;
      end
      else
      begin : g_link
        assign st_wr  = !flg[k-1].output_ready_n;
        assign st_din = q[k-1];
      end
      if (k == `FWE_STAGES-1)
      begin : g_tail
        assign st_rd = !rd_en_n;
      end
      else
      begin : g_mid
        assign st_rd = !flg[k+1].input_ready_n;
      end
      fwe_stage u_stage (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clr     (clr_ff),
        .wr_en   (st_wr),
        .wr_data (st_din),
        .rd_en   (st_rd),
        .rd_data (q[k]),
        .flags   (flg[k]),
        .level   (lvl[k])
      );
    end
  endgenerate

  assign input_ready_n  = flg[0].input_ready_n;
  assign output_ready_n = flg[`FWE_STAGES-1].output_ready_n;
  assign rd_data        = q[`FWE_STAGES-1];

  always_comb
  begin
    lvl_total = '0;
    for (int i = 0; i < `FWE_STAGES; i++)
      lvl_total = lvl_total + {{(`FWE_TOT_W-`FWE_CNT_W){1'b0}}, lvl[i]};
  end

  // ========================================================================
  // Register slave: one wait cycle, answer on the second edge
  assign reg_idx         = avs_address[3:2];
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wait_ff <= 1'b1;
    else if ((avs_read || avs_write) && wait_ff)
      wait_ff <= 1'b0;
    else
      wait_ff <= 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_ff <= '0;
    else if (avs_read && wait_ff)
    begin
      rdata_ff <= '0;
      if (reg_idx == `FWE_STAT_OFS)
      begin
        rdata_ff[`FWE_TOT_W-1:0]     <= lvl_total;
        rdata_ff[`FWE_STAT_ORN_BIT]  <= output_ready_n;
        rdata_ff[`FWE_STAT_IRN_BIT]  <= input_ready_n;
      end
    end
  end

  // A write of one to the clear bit pulses clear for one cycle and empties the whole chain.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clr_ff <= 1'b0;
    else
      clr_ff <= avs_write && !wait_ff && (reg_idx == `FWE_CTRL_OFS)
                && avs_byteenable[0] && avs_writedata[`FWE_CTRL_CLR_BIT];
  end

  // ========================================================================
  // Checks
  assign first_take = !wr_en_n && !input_ready_n && (lvl_total == '0);

  // The ripple timer runs from a write into an empty chain until the tail
  // shows the word, so the latency can be held against the ripple budget.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ripple_run_ff <= 1'b0;
      ripple_cnt_ff <= '0;
    end
    else if (clr_ff)
    begin
      ripple_run_ff <= 1'b0;
      ripple_cnt_ff <= '0;
    end
    else if (first_take)
    begin
      ripple_run_ff <= 1'b1;
      ripple_cnt_ff <= '0;
    end
    else if (ripple_run_ff && !output_ready_n)
      ripple_run_ff <= 1'b0;
    else if (ripple_run_ff && (ripple_cnt_ff != 4'hF))
      ripple_cnt_ff <= ripple_cnt_ff + 4'h1;
  end

  a_chain_ripple_delay: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    first_take |-> (output_ready_n [*8] ##1 !output_ready_n))
    else $error("Ripple delay through the chain is not seven cycles.");

  a_ripple_budget: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (ripple_run_ff && !output_ready_n) |-> (ripple_cnt_ff == `FWE_RIPPLE_CYC))
    else $error("Tail word arrived off the ripple budget.");

  a_ripple_bounded: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    ripple_run_ff |-> (ripple_cnt_ff <= `FWE_RIPPLE_CYC))
    else $error("Tail word still missing after the ripple budget.");

  a_chain_depth_sum: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (lvl_total <= `FWE_TOT_CAP) && ((lvl_total != `FWE_TOT_CAP) || input_ready_n))
    else $error("Chain capacity differs from the sum of stage depths.");

  a_tail_word_hold: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (!output_ready_n && rd_en_n) |=> (!output_ready_n && $stable(rd_data)))
    else $error("Tail word changed or vanished without a read.");

  a_tail_no_gap: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (!output_ready_n && !rd_en_n && (lvl[`FWE_STAGES-1] > 10'h1)) |=> !output_ready_n)
    else $error("Queued tail word was held back after a read.");

  a_level_on_write: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (!wr_en_n && !input_ready_n && (rd_en_n || output_ready_n))
      |=> (lvl_total == $past(lvl_total) + 11'h1))
    else $error("Accepted word did not raise the chain level by one.");

  a_level_on_read: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (!rd_en_n && !output_ready_n && (wr_en_n || input_ready_n))
      |=> (lvl_total == $past(lvl_total) - 11'h1))
    else $error("Taken word did not lower the chain level by one.");

  a_bubble_to_head: assert property (
    @(posedge clk_sys) disable iff (rst || clr_ff)
    (input_ready_n && (lvl_total == `FWE_TOT_CAP) && !rd_en_n && !output_ready_n)
      |-> ##2 !input_ready_n)
    else $error("Freed location did not reach the head in two cycles.");

  a_clear_empties: assert property (
    @(posedge clk_sys) disable iff (rst)
    clr_ff |=> (output_ready_n && !input_ready_n && (lvl_total == '0)))
    else $error("Clear left words in the chain.");

endmodule : fwe_top

// file: src/fwe_params.svh
`ifndef FWE_PARAMS_SVH
`define FWE_PARAMS_SVH

// ==========================================================================
// Geometry
`define FWE_DATA_W        18
`define FWE_DEPTH         10'h200
`define FWE_PTR_W         9
`define FWE_CNT_W         10
`define FWE_STAGES        2
`define FWE_TOT_W         11
`define FWE_TOT_CAP       11'h402

// ==========================================================================
// Timing in transfer and read clock cycles
`define FWE_XFER_CYC      4
`define FWE_RDCLK_CYC     3
`define FWE_DLY_LAST      2'h2
`define FWE_RIPPLE_CYC    4'h7

// ==========================================================================
// Register map
`define FWE_CTRL_OFS      2'h0
`define FWE_STAT_OFS      2'h1
`define FWE_CTRL_CLR_BIT  0
`define FWE_STAT_ORN_BIT  16
`define FWE_STAT_IRN_BIT  17

`endif

// file: src/fwe_pkg.sv
package fwe_pkg;

  typedef logic [17:0] fwe_data_t;

  typedef struct packed
  {
    logic output_ready_n;
    logic input_ready_n;
  } fwe_flags_t;

endpackage : fwe_pkg

// file: src/fwe_stage.sv
`timescale 1ns/1ps
`include "fwe_params.svh"

module fwe_stage (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clr,
  input  wire logic                   wr_en,
  input  wire fwe_pkg::fwe_data_t     wr_data,
  input  wire logic                   rd_en,
  output      fwe_pkg::fwe_data_t     rd_data,
  output      fwe_pkg::fwe_flags_t    flags,
  output      logic [`FWE_CNT_W-1:0]  level
);

  logic [`FWE_DATA_W-1:0] mem [0:(1 << `FWE_PTR_W)-1];
  logic [`FWE_PTR_W-1:0]  wptr_ff;
  logic [`FWE_PTR_W-1:0]  rptr_ff;
  logic [`FWE_CNT_W-1:0]  cnt_ff;
  logic [`FWE_CNT_W-1:0]  nxt_cnt;
  logic [1:0]             dly_ff;
  logic                   or_n_ff;
  logic                   ir_n_ff;
  fwe_pkg::fwe_data_t     data_ff;
  logic                   wr_take;
  logic                   rd_take;
  logic                   load_first;
  logic                   refill;
  logic                   pop;

  assign wr_take    = wr_en && !ir_n_ff;
  assign rd_take    = rd_en && !or_n_ff;
  assign load_first = or_n_ff && (cnt_ff != '0) && (dly_ff == `FWE_DLY_LAST);
  assign refill     = rd_take && (cnt_ff != '0);
  assign pop        = load_first || refill;
  assign nxt_cnt    = cnt_ff + {{(`FWE_CNT_W-1){1'b0}}, wr_take}
                      - {{(`FWE_CNT_W-1){1'b0}}, pop};

  assign rd_data              = data_ff;
  assign flags.output_ready_n = or_n_ff;
  assign flags.input_ready_n  = ir_n_ff;
  assign level = cnt_ff + {{(`FWE_CNT_W-1){1'b0}}, !or_n_ff};

  // ========================================================================
  // Storage
  always_ff @(posedge clk_sys)
  begin
    if (wr_take)
      mem[wptr_ff] <= wr_data;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else if (clr)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      if (wr_take)
        wptr_ff <= wptr_ff + 1'b1;
      if (pop)
        rptr_ff <= rptr_ff + 1'b1;
    end
  end

  // ========================================================================
  // Occupancy and input ready
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= '0;
      ir_n_ff <= 1'b1;
    end
    else if (clr)
    begin
      cnt_ff  <= '0;
      ir_n_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      ir_n_ff <= (nxt_cnt == `FWE_DEPTH);
    end
  end

  // ========================================================================
  // First word fall through delay, paid only when the stage was empty
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dly_ff <= '0;
    else if (clr || !or_n_ff || (cnt_ff == '0))
      dly_ff <= '0;
    else if (dly_ff != `FWE_DLY_LAST)
      dly_ff <= dly_ff + 1'b1;
  end

  // ========================================================================
  // Output word and output ready
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      or_n_ff <= 1'b1;
      data_ff <= '0;
    end
    else if (clr)
      or_n_ff <= 1'b1;
    else if (pop)
    begin
      data_ff <= mem[rptr_ff];
      or_n_ff <= 1'b0;
    end
    else if (rd_take)
      or_n_ff <= 1'b1;
  end

  // ========================================================================
  // Checks
  a_first_word_latency: assert property (
    @(posedge clk_sys) disable iff (rst || clr)
    (wr_take && or_n_ff && (cnt_ff == '0)) |-> ##4 !or_n_ff)
    else $error("First word did not reach the output in three cycles.");

  a_output_word_hold: assert property (
    @(posedge clk_sys) disable iff (rst || clr)
    (!or_n_ff && !rd_en) |=> (!or_n_ff && $stable(data_ff)))
    else $error("Presented word dropped without a read.");

  a_refill_no_gap: assert property (
    @(posedge clk_sys) disable iff (rst || clr)
    refill |=> !or_n_ff)
    else $error("Queued word was not presented on the next cycle.");

  a_bubble_up_flag: assert property (
    @(posedge clk_sys) disable iff (rst || clr)
    (ir_n_ff && refill) |=> (!ir_n_ff ##1 (!ir_n_ff || $past(wr_take))))
    else $error("Freed location did not lower input ready.");

  a_flag_one_cycle: assert property (
    @(posedge clk_sys) disable iff (rst || clr)
    (or_n_ff && (cnt_ff != '0) && (dly_ff == `FWE_DLY_LAST)) |=> !or_n_ff)
    else $error("Output ready lagged by more than one cycle.");

endmodule : fwe_stage

// file: bench/fwe_reader.sv
`timescale 1ns/1ps

// ==========================================================================
// Tail reader
// Reads one cycle behind its go input and checks that words arrive in order.
module fwe_reader (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               go,
  input  wire logic               output_ready_n,
  input  wire fwe_pkg::fwe_data_t rd_data,
  output      logic               rd_en_n,
  output      logic [11:0]        taken,
  output      logic [11:0]        bad_words
);
  fwe_pkg::fwe_data_t exp_ff;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      rd_en_n <= 1'b1;
    else
      rd_en_n <= ~go;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      exp_ff <= 18'h0;
      taken <= 12'h0;
      bad_words <= 12'h0;
    end
    else if (!rd_en_n && !output_ready_n)
    begin
      exp_ff <= exp_ff + 18'h1;
      taken <= taken + 12'h1;
      if (rd_data !== exp_ff)
        bad_words <= bad_words + 12'h1;
    end
endmodule : fwe_reader

// file: bench/fwe_top_test.sv
`timescale 1ns/1ps
`include "fwe_params.svh"

`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("MISMATCH %0t got %h expected %h", $time, a, b); \
    end \
  end

module fwe_top_test;
  logic               clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]         avs_address, avs_byteenable;
  logic [31:0]        avs_writedata, avs_readdata, q;
  logic               wr_en_n, input_ready_n, rd_en_n, output_ready_n, go;
  fwe_pkg::fwe_data_t wr_data, rd_data, wr_idx;
  logic [11:0]        taken, bad_words;
  int                 bad_count, comparisons;

  fwe_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wr_en_n(wr_en_n), .wr_data(wr_data),
    .input_ready_n(input_ready_n), .rd_en_n(rd_en_n), .rd_data(rd_data),
    .output_ready_n(output_ready_n));

  fwe_reader far_reader (.clk_sys(clk_sys), .rst(rst), .go(go),
    .output_ready_n(output_ready_n), .rd_data(rd_data), .rd_en_n(rd_en_n),
    .taken(taken), .bad_words(bad_words));

  // ==========================================================================
  // Closing and bus tasks
  task finish_test;
    $display("Counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task give_up;
    bad_count++;
    $display("MISMATCH %0t wait ran out", $time);
    finish_test();
  endtask : give_up

  task av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
               input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
      give_up();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av_xfer

  // Streams numbered words while the head is ready; stops after n words or limit edges.
  task burst(input int n, input int limit, output int got);
    int e;
    got = 0;
    @(posedge clk_sys);
    wr_en_n <= 1'b0;
    wr_data <= wr_idx;
    for (e = 0; e < limit && got < n; e++)
    begin
      @(posedge clk_sys);
      if (input_ready_n === 1'b0)
      begin
        got++;
        wr_idx++;
        wr_data <= wr_idx;
      end
    end
    wr_en_n <= 1'b1;
  endtask : burst

  // ==========================================================================
  // Scenarios
  task first_word;
    int got, n;
    burst(1, 20, got);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      #1;
    end
    while (output_ready_n !== 1'b0 && n < 20);
    `CHK(n, `FWE_XFER_CYC * (`FWE_STAGES - 1) + `FWE_RDCLK_CYC)
    `CHK(rd_data, 18'h0)
  endtask : first_word

  task no_ripple;
    int got;
    burst(4, 20, got);
    repeat (20) @(posedge clk_sys);
    go <= 1'b1;
    repeat (6) @(posedge clk_sys);
    go <= 1'b0;
    #1;
    `CHK(taken, 12'h5)
    `CHK(output_ready_n, 1'b1)
  endtask : no_ripple

  task fill_and_bubble;
    int got, n;
    burst(2000, 2500, got);
    `CHK(got, `FWE_TOT_CAP)
    `CHK(input_ready_n, 1'b1)
    av_xfer(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q, 32'h0002_0402)
    av_xfer(1'b1, 4'h0, 32'h1, 4'hE);
    av_xfer(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q, 32'h0002_0402)
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (n = 0; n < 50 && input_ready_n !== 1'b0; n++)
      @(posedge clk_sys);
    `CHK(input_ready_n, 1'b0)
    av_xfer(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q, 32'h0000_0401)
  endtask : fill_and_bubble

  task clear_chain;
    av_xfer(1'b1, 4'h0, 32'h1, 4'hF);
    av_xfer(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q, 32'h0001_0000)
    av_xfer(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    av_xfer(1'b0, 4'h8, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    `CHK(bad_words, 12'h0)
  endtask : clear_chain

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    give_up();
  end

  initial
  begin
    bad_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {avs_read, avs_write, go} = 3'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    wr_en_n = 1'b1;
    wr_data = 18'h0;
    wr_idx = 18'h0;
    repeat (20) @(posedge clk_sys);
    `CHK(input_ready_n, 1'b1)
    `CHK(output_ready_n, 1'b1)
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(input_ready_n, 1'b0)
    first_word();
    no_ripple();
    fill_and_bubble();
    clear_chain();
    finish_test();
  end
endmodule : fwe_top_test
